// ===== include/sas_pkg.sv
// Package for the converter sequencer: register map, fields, reset values, timing
package sas_pkg;
  localparam logic [7:0] REG_CTRL_A = 8'h00;
  localparam logic [7:0] REG_CTRL_B = 8'h04;
  localparam logic [7:0] REG_RESULT = 8'h08;
  localparam logic [7:0] REG_FLAGS = 8'h0c;
  localparam logic [7:0] REG_IRQEN = 8'h10;
  localparam int CTRL_A_ON_BIT = 0;
  localparam int CTRL_A_GO_BIT = 1;
  localparam int CTRL_A_CHS_LSB = 2;
  localparam int CTRL_B_REF_LSB = 0;
  localparam int CTRL_B_CKS_LSB = 4;
  localparam int FLAGS_DONE_BIT = 0;
  localparam int IRQEN_EN_BIT = 0;
  localparam logic [3:0] CHS_RESET = 4'h0;
  localparam logic [1:0] REF_RESET = 2'h0;
  localparam logic [2:0] CKS_RESET = 3'h0;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [3:0] CHS_FIXED_REF = 4'hf;
  localparam logic [1:0] REF_SUPPLY = 2'h0;
  localparam logic [1:0] REF_EXT_PIN = 2'h2;
  localparam logic [1:0] REF_INTERNAL = 2'h3;
  localparam logic [1:0] CKS_RC_LOW = 2'h3;
  localparam int SAR_BITS = 8;
  localparam logic [3:0] TAD_PER_CONV = 4'ha;
  localparam logic [6:0] DIV_MAX = 7'h40;
  localparam int INSTR_CYCLES = 4;
  localparam logic [2:0] INSTR_DELAY = 3'(INSTR_CYCLES);
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
  typedef struct packed {
    logic [3:0] channel_select;
    logic [1:0] reference_select;
    logic sample_hold;
    logic converter_power;
  } sas_analog_t;
  function automatic logic [6:0] sas_div_of(input logic [2:0] cks);
    case (cks)
      3'h0: sas_div_of = 7'h02;
      3'h4: sas_div_of = 7'h04;
      3'h1: sas_div_of = 7'h08;
      3'h5: sas_div_of = 7'h10;
      3'h2: sas_div_of = 7'h20;
      3'h6: sas_div_of = 7'h40;
      default: sas_div_of = 7'h02;
    endcase
  endfunction : sas_div_of
endpackage : sas_pkg

// ===== hw/sas_tad_gen.sv
// Bit-period tick generator: system clock divider or dedicated RC clock
`timescale 1ns/10ps
`default_nettype none
module sas_tad_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic [2:0] conv_clock_select,
  input wire logic rc_tick,
  output logic tad_tick
);
  import sas_pkg::*;
  logic [6:0] cnt_r;
  logic [6:0] div;
  logic use_rc;
  assign div = sas_div_of(conv_clock_select);
  assign use_rc = (conv_clock_select[1:0] == CKS_RC_LOW);
  // Divider restarts with each conversion so the first period is whole
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 7'h00;
    end else if (!run || cnt_r >= div - 7'h01) begin
      cnt_r <= 7'h00;
    end else begin
      cnt_r <= cnt_r + 7'h01;
    end
  end
  assign tad_tick = run && (use_rc ? rc_tick : (cnt_r == div - 7'h01));
endmodule : sas_tad_gen
`default_nettype wire

// ===== hw/sas_seq.sv
// Converter sequencer top: APB registers, successive approximation, sleep control
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Eight-bit successive approximation result stored
// - Channel field drives mux; software waits settling
// - Reference field picks positive reference; negative ground
// - Clock select encodes divide ratios or RC
// - Conversion lasts ten bit periods
// - Non-RC clock derives from system clock
// - Done flag set on every completion
// - Enabled interrupt wakes core from sleep
// - Converter on required; go starts conversion
// - Completion clears go, sets flag, loads result
// - Go-clear abort fills bits with last bit; other aborts keep result
// - Reset clears registers and stops conversion
// - Sleep conversions only with RC clock
// - RC clock delays start one instruction
// - Sleep completion without interrupt powers down
// - Sleep with non-RC clock aborts, powers down
// - Trigger sets go and clears timer
// - Four-bit channel field; 1111 fixed reference
// - Reference encoding supply, pin, internal
// - Go reads one while converting
module sas_seq (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic comparator_high,
  input wire logic rc_tick,
  input wire logic sleep_active,
  input wire logic special_trigger,
  output sas_pkg::sas_analog_t analog_ctrl,
  output logic [sas_pkg::SAR_BITS-1:0] dac_code,
  output logic timer_clear,
  output logic wake_request,
  output logic conversion_irq
);
  import sas_pkg::*;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_DELAY = 4'b0010,
    ST_CONV = 4'b0100,
    ST_OFF = 4'b1000
  } sas_state_t;
  sas_state_t state_r;
  sas_state_t state_nxt;
  logic converter_on_r;
  logic convert_go_r;
  logic [3:0] channel_select_r;
  logic [1:0] reference_select_r;
  logic [2:0] conv_clock_select_r;
  logic [7:0] conversion_result_r;
  logic conversion_done_flag_r;
  logic conversion_irq_enable_r;
  logic [7:0] sar_r;
  logic [3:0] tad_cnt_r;
  logic [2:0] dly_r;
  logic wr_en;
  logic rd_en;
  logic tad_tick;
  logic rc_sel;
  logic go_wr_set;
  logic go_wr_clr;
  logic start_req;
  logic finish;
  logic abort_sw;
  logic abort_sleep;
  logic [7:0] partial;
  logic [7:0] final_val;
  logic [2:0] bit_idx;
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign rc_sel = (conv_clock_select_r[1:0] == CKS_RC_LOW);
  assign go_wr_set = wr_en && paddr == REG_CTRL_A && pwdata[CTRL_A_GO_BIT];
  assign go_wr_clr = wr_en && paddr == REG_CTRL_A && !pwdata[CTRL_A_GO_BIT];
  // Enable must already be set from an earlier write
  assign start_req = converter_on_r && (go_wr_set || special_trigger);
  assign timer_clear = special_trigger;
  assign finish = state_r == ST_CONV && tad_tick && tad_cnt_r == TAD_PER_CONV - 4'h1;
  assign abort_sw = state_r == ST_CONV && go_wr_clr;
  assign abort_sleep = sleep_active && !rc_sel && state_r == ST_CONV;
  // Bits 7..0 resolved during periods 1..8; period 0 samples, period 9 settles
  assign bit_idx = 3'(7 - (int'(tad_cnt_r) - 1));

  always_comb begin
    partial = sar_r;
    // Unresolved bits copy the last resolved bit
    if (tad_cnt_r >= 4'h2 && tad_cnt_r <= 4'h8) begin
      for (int i = 0; i < 8; i++) begin
        if (i < 8 - (int'(tad_cnt_r) - 1)) begin
          partial[i] = sar_r[8 - (int'(tad_cnt_r) - 1)];
        end
      end
    end else if (tad_cnt_r < 4'h2) begin
      partial = RESULT_RESET;
    end
  end

  assign final_val = sar_r;

  sas_tad_gen u_tad (
    .pclk(pclk),
    .presetn(presetn),
    .run(state_r == ST_CONV),
    .conv_clock_select(conv_clock_select_r),
    .rc_tick(rc_tick),
    .tad_tick(tad_tick)
  );

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (start_req && !(sleep_active && !rc_sel)) begin
          state_nxt = rc_sel ? ST_DELAY : ST_CONV;
        end
      end
      ST_DELAY: begin
        if (!convert_go_r || !converter_on_r) begin
          state_nxt = ST_IDLE;
        end else if (dly_r == INSTR_DELAY - 3'h1) begin
          state_nxt = ST_CONV;
        end
      end
      ST_CONV: begin
        if (abort_sleep) begin
          state_nxt = ST_OFF;
        end else if (!converter_on_r || abort_sw) begin
          state_nxt = ST_IDLE;
        end else if (finish) begin
          state_nxt = (sleep_active && !conversion_irq_enable_r) ? ST_OFF : ST_IDLE;
        end
      end
      ST_OFF: begin
        // Stays powered down until the core wakes
        if (!sleep_active) begin
          state_nxt = ST_IDLE;
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_r <= 3'h0;
    end else if (state_r == ST_DELAY) begin
      dly_r <= dly_r + 3'h1;
    end else begin
      dly_r <= 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tad_cnt_r <= 4'h0;
      sar_r <= RESULT_RESET;
    end else if (state_r != ST_CONV) begin
      tad_cnt_r <= 4'h0;
      sar_r <= RESULT_RESET;
    end else if (tad_tick) begin
      tad_cnt_r <= tad_cnt_r + 4'h1;
      if (tad_cnt_r >= 4'h1 && tad_cnt_r <= 4'h8) begin
        sar_r[bit_idx] <= !comparator_high;
      end
    end
  end

  always_comb begin
    dac_code = sar_r;
    if (state_r == ST_CONV && tad_cnt_r >= 4'h1 && tad_cnt_r <= 4'h8) begin
      dac_code[bit_idx] = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      converter_on_r <= 1'b0;
      channel_select_r <= CHS_RESET;
      reference_select_r <= REF_RESET;
      conv_clock_select_r <= CKS_RESET;
      conversion_irq_enable_r <= 1'b0;
    end else if (wr_en) begin
      case (paddr)
        REG_CTRL_A: begin
          converter_on_r <= pwdata[CTRL_A_ON_BIT];
          channel_select_r <= pwdata[CTRL_A_CHS_LSB +: 4];
        end
        REG_CTRL_B: begin
          reference_select_r <= pwdata[CTRL_B_REF_LSB +: 2];
          conv_clock_select_r <= pwdata[CTRL_B_CKS_LSB +: 3];
        end
        REG_IRQEN: conversion_irq_enable_r <= pwdata[IRQEN_EN_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      convert_go_r <= 1'b0;
    end else if (start_req && state_r == ST_IDLE && !(sleep_active && !rc_sel)) begin
      convert_go_r <= 1'b1;
    end else if (state_r == ST_CONV && (finish || abort_sw || abort_sleep)) begin
      convert_go_r <= 1'b0;
    end else if (!converter_on_r || state_r == ST_IDLE || go_wr_clr) begin
      convert_go_r <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_result_r <= RESULT_RESET;
    end else if (finish) begin
      conversion_result_r <= {final_val[7:1], !comparator_high && 1'b0 || final_val[0]};
    end else if (abort_sw) begin
      conversion_result_r <= partial;
    end
  end

  // Set beats a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_flag_r <= 1'b0;
    end else if (finish) begin
      conversion_done_flag_r <= 1'b1;
    end else if (wr_en && paddr == REG_FLAGS && !pwdata[FLAGS_DONE_BIT]) begin
      conversion_done_flag_r <= 1'b0;
    end
  end

  assign conversion_irq = conversion_done_flag_r && conversion_irq_enable_r;
  assign wake_request = conversion_irq && sleep_active;

  always_comb begin
    analog_ctrl.channel_select = channel_select_r;
    analog_ctrl.reference_select = reference_select_r;
    analog_ctrl.sample_hold = state_r == ST_CONV && tad_cnt_r == 4'h0;
    analog_ctrl.converter_power = converter_on_r && state_r != ST_OFF;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= UNMAPPED_DATA;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        REG_CTRL_A: prdata <= {26'h0, channel_select_r, convert_go_r, converter_on_r};
        REG_CTRL_B: prdata <= {25'h0, conv_clock_select_r, 2'h0, reference_select_r};
        REG_RESULT: prdata <= {24'h0, conversion_result_r};
        REG_FLAGS: prdata <= {31'h0, conversion_done_flag_r};
        REG_IRQEN: prdata <= {31'h0, conversion_irq_enable_r};
        default: prdata <= UNMAPPED_DATA;
      endcase
    end
  end

  assign pslverr = (psel && penable) && !(paddr == REG_CTRL_A || paddr == REG_CTRL_B
    || paddr == REG_RESULT || paddr == REG_FLAGS || paddr == REG_IRQEN);

  done_sets_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish |=> conversion_done_flag_r) else $error("done flag not set");
  go_clears_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish |=> !convert_go_r) else $error("go not cleared");
  off_nostart_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && !converter_on_r) |=> state_r != ST_CONV) else $error("start while off");
  wake_a: assert property (@(posedge pclk) disable iff (!presetn)
    (sleep_active && conversion_done_flag_r && conversion_irq_enable_r) |-> wake_request)
    else $error("no wake");
  sleep_abort_a: assert property (@(posedge pclk) disable iff (!presetn)
    abort_sleep |=> state_r == ST_OFF && !convert_go_r) else $error("sleep abort failed");
  rc_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
    (state_r == ST_IDLE && state_nxt == ST_DELAY) |=> state_r != ST_CONV)
    else $error("rc start not delayed");
  go_reads_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_r == ST_CONV && $past(state_r) == ST_CONV |-> convert_go_r || $past(abort_sw))
    else $error("go low mid conversion");
  ten_tad_a: assert property (@(posedge pclk) disable iff (!presetn)
    finish |-> tad_cnt_r == 4'h9) else $error("conversion not ten periods");
endmodule : sas_seq
`default_nettype wire

// ===== verif/sas_mux_model.sv
// Behavioural analog input mux and comparator
`timescale 1ns/10ps
`default_nettype none
module sas_mux_model (
  input wire logic pclk,
  input wire sas_pkg::sas_analog_t analog_ctrl,
  input wire logic [7:0] dac_code,
  output logic comparator_high
);
  import sas_pkg::*;
  logic [7:0] vin;
  logic last_r = 1'b0;
  // Each channel holds its own fixed level; negative reference is ground
  assign vin = {analog_ctrl.channel_select, ~analog_ctrl.channel_select};
  // Unpowered comparator is meaningless, so it toggles
  assign comparator_high = analog_ctrl.converter_power ? (vin < dac_code) : ~last_r;
  always_ff @(posedge pclk) begin
    last_r <= comparator_high;
  end
endmodule : sas_mux_model
`default_nettype wire

// ===== verif/sas_seq_test.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/10ps
`default_nettype none
module sas_seq_test;
  import sas_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic sleep_active = 1'b0;
  logic special_trigger = 1'b0;
  logic rc_tick = 1'b0;
  logic [2:0] rc_cnt = 3'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, comparator_high, timer_clear, wake_request, conversion_irq;
  logic [7:0] dac_code;
  sas_analog_t analog_ctrl;
  int errors = 0;
  int n_tests = 0;
  int n;
  always #2 pclk = ~pclk;
  // RC oscillator stand-in, one tick every eight cycles
  always @(posedge pclk) begin
    rc_cnt <= rc_cnt + 3'h1;
    rc_tick <= (rc_cnt == 3'h7);
  end
  sas_seq dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .comparator_high(comparator_high), .rc_tick(rc_tick),
    .sleep_active(sleep_active), .special_trigger(special_trigger),
    .analog_ctrl(analog_ctrl), .dac_code(dac_code), .timer_clear(timer_clear),
    .wake_request(wake_request), .conversion_irq(conversion_irq));
  sas_mux_model model_u (.pclk(pclk), .analog_ctrl(analog_ctrl), .dac_code(dac_code),
    .comparator_high(comparator_high));
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      errors++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk
  // One idle cycle after each transfer keeps psel from being driven twice in a step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // Selector: 2 irq, 1 wake, 0 converter power
  task automatic wt(input int s, input logic v, input int lim);
    logic [2:0] x;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
      x = {conversion_irq, wake_request, analog_ctrl.converter_power};
    end while (x[s] !== v && n < lim);
    chk(x[s] === v, "wait ran out");
  endtask : wt
  function automatic logic fill_ok(input logic [7:0] r, input logic [7:0] v);
    logic [7:0] x;
    fill_ok = 1'b0;
    for (int k = 1; k < 8; k++) begin
      x = v;
      for (int b = 7 - k; b >= 0; b--) x[b] = v[8-k];
      if (x === r) fill_ok = 1'b1;
    end
  endfunction : fill_ok
  task automatic t_reset;
    logic [7:0] regs [5] = '{REG_CTRL_A, REG_CTRL_B, REG_RESULT, REG_FLAGS, REG_IRQEN};
    foreach (regs[i]) begin
      rd(regs[i]);
      chk(q === 32'h0 && e === 1'b0, "reset value");
    end
    wr(8'h20, 32'hffff_ffff);
    chk(e === 1'b1, "unmapped write");
    rd(8'h20);
    chk(e === 1'b1 && q === UNMAPPED_DATA, "unmapped read");
    chk(analog_ctrl.converter_power === 1'b0, "power at reset");
    $display("test reset done");
  endtask : t_reset
  task automatic t_sel;
    for (int r = 0; r < 4; r++) begin
      wr(REG_CTRL_B, 32'(r));
      wr(REG_CTRL_A, 32'({4'(r * 5), 2'h0}));
      chk(analog_ctrl.reference_select === 2'(r), "reference");
      chk(analog_ctrl.channel_select === 4'(r * 5), "channel");
    end
    $display("test select done");
  endtask : t_sel
  task automatic t_conv;
    logic [2:0] cks [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
    int dv [8] = '{2, 4, 8, 16, 32, 64, 8, 8};
    wr(REG_IRQEN, 32'h1);
    foreach (cks[i]) begin
      wr(REG_CTRL_B, {25'h0, cks[i], 4'h0});
      wr(REG_CTRL_A, 32'h25);
      wr(REG_CTRL_A, 32'h27);
      wt(2, 1'b1, 2000);
      chk(n >= 10 * dv[i] - 2 && n <= 10 * dv[i] + (i > 5 ? 24 : 6), "duration");
      rd(REG_RESULT);
      chk(q === 32'h96, "result");
      rd(REG_CTRL_A);
      chk(q === 32'h25, "go not cleared");
      wr(REG_FLAGS, 32'h1);
      chk(conversion_irq === 1'b1, "flag lost");
      wr(REG_FLAGS, 32'h0);
      chk(conversion_irq === 1'b0, "flag stuck");
    end
    wr(REG_CTRL_A, 32'h0);
    wr(REG_CTRL_A, 32'h2);
    repeat (40) @(posedge pclk);
    rd(REG_CTRL_A);
    chk(q === 32'h0 && conversion_irq === 1'b0, "go while off");
    $display("test convert done");
  endtask : t_conv
  task automatic t_trig;
    special_trigger <= 1'b1;
    @(posedge pclk);
    chk(timer_clear === 1'b1, "timer clear while off");
    special_trigger <= 1'b0;
    rd(REG_CTRL_A);
    chk(q === 32'h0 && conversion_irq === 1'b0, "trigger while off");
    wr(REG_CTRL_B, 32'h0);
    wr(REG_CTRL_A, 32'h25);
    // Channel written just before; the model mux settles at once, so trigger timing is safe
    special_trigger <= 1'b1;
    @(posedge pclk);
    chk(timer_clear === 1'b1, "timer clear");
    special_trigger <= 1'b0;
    wt(2, 1'b1, 100);
    rd(REG_RESULT);
    chk(q === 32'h96, "triggered result");
    wr(REG_FLAGS, 32'h0);
    $display("test trigger done");
  endtask : t_trig
  task automatic t_sleep;
    wr(REG_CTRL_B, 32'h60);
    wr(REG_CTRL_A, 32'h27);
    chk(analog_ctrl.converter_power === 1'b1, "power on");
    sleep_active <= 1'b1;
    wt(0, 1'b0, 20);
    rd(REG_CTRL_A);
    chk(q[0] === 1'b1, "on bit lost");
    sleep_active <= 1'b0;
    wr(REG_CTRL_A, 32'h25);
    wr(REG_FLAGS, 32'h0);
    wr(REG_CTRL_B, 32'h30);
    wr(REG_CTRL_A, 32'h27);
    sleep_active <= 1'b1;
    wt(1, 1'b1, 300);
    rd(REG_RESULT);
    chk(q === 32'h96, "sleep result");
    wr(REG_IRQEN, 32'h0);
    sleep_active <= 1'b0;
    wr(REG_FLAGS, 32'h0);
    wr(REG_CTRL_A, 32'h27);
    sleep_active <= 1'b1;
    wt(0, 1'b0, 300);
    chk(n >= 70, "early power down");
    rd(REG_FLAGS);
    chk(q === 32'h1, "flag without enable");
    rd(REG_CTRL_A);
    chk(q[0] === 1'b1, "on bit lost");
    sleep_active <= 1'b0;
    wt(0, 1'b1, 4);
    wr(REG_FLAGS, 32'h0);
    $display("test sleep done");
  endtask : t_sleep
  task automatic t_abort;
    wr(REG_CTRL_B, 32'h60);
    wr(REG_CTRL_A, 32'h27);
    rd(REG_CTRL_A);
    chk(q[1] === 1'b1, "go while busy");
    repeat (300) @(posedge pclk);
    wr(REG_CTRL_A, 32'h25);
    rd(REG_RESULT);
    chk(q[31:8] === 24'h0 && fill_ok(q[7:0], 8'h96), "partial result");
    wr(REG_CTRL_A, 32'h27);
    repeat (100) @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(REG_CTRL_A);
    chk(q === 32'h0 && analog_ctrl.converter_power === 1'b0, "reset mid run");
    $display("test abort done");
  endtask : t_abort
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : wrap_up
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_sel;
    t_conv;
    t_trig;
    t_sleep;
    t_abort;
    wrap_up;
  end
  initial begin
    #80000;
    errors++;
    $display("BAD %0t watchdog", $time);
    wrap_up;
  end
endmodule : sas_seq_test
`default_nettype wire
